// [core/jbs_tap.sv]
`timescale 1ns/1ps
// Contract
// - Opcode 1111 selects one-bit bypass path
// - Opcode 0100 puts boundary chain in path
// - Sample snapshots pin and core values
// - Preload fills parallel output latch
// - Opcode 0000 drives pins from latch
// - Captured output cells reach pins only through update
// - Next pass shifts in while results out
// - Reset or test-logic-reset loads IDCODE
// - Clamp and high-impedance instructions supported
// - Clock, reset, test pins not in chain
// - Instruction stays until another loaded
// - Instructions ignored during standby
// - Instruction register sixteen bits wide
// - Boundary chain has 333 cells
// - Sample on rising, output tristated outside shift
// - Output changes on falling clock edge
`include "jbs_defs.svh"

module jbs_tap
    import jbs_pkg::*;
#(
    parameter int NUM_PINS = `JBS_NUM_PINS, // Scanned pins, three cells each
    parameter logic [`JBS_ID_W-1:0] IDCODE_VAL = `JBS_IDCODE_VAL // Arbitrary identification value
) (
    input wire logic sys_clk, // System clock
    input wire logic arst_n, // System reset, active low
    input wire logic tck, // Test clock from the tester
    input wire logic trst_n, // Test reset, active low
    input wire logic tms, // Test mode select
    input wire logic tdi, // Test data in
    output logic tdo, // Test data out
    output logic tdo_oe_n, // Test data out enable, active low
    input wire logic standby, // Chip in standby, sys_clk domain
    input wire logic [NUM_PINS-1:0] pad_in, // Levels seen at the pads
    output logic [NUM_PINS-1:0] pad_out, // Levels driven to the pads
    output logic [NUM_PINS-1:0] pad_oe_n, // Pad drive enables, active low
    input wire logic [NUM_PINS-1:0] core_out, // Core output values
    input wire logic [NUM_PINS-1:0] core_oe_n, // Core drive enables, active low
    output logic [NUM_PINS-1:0] core_in // Pad levels handed to the core
);

    // Chain layout: inputs on top, then outputs, controls at the tdo end
    localparam int BSR_LEN = 3 * NUM_PINS;
    localparam int XW = 1 + 3 * NUM_PINS;

    // ==========================================================
    // Test clock domain state
    // ==========================================================
    typedef struct packed {
        jbs_tap_t tap;
        logic [`JBS_IR_W-1:0] ir;
        logic [`JBS_IR_W-1:0] ir_sh;
        logic [BSR_LEN-1:0] bsr;
        logic [`JBS_ID_W-1:0] id_sh;
        logic byp;
        logic [NUM_PINS-1:0] upd_out;
        logic [NUM_PINS-1:0] upd_ctl;
        logic upd_tog;
        logic drive;
        logic highz;
    } jbs_tck_st_t;

    // Falling-edge output state
    typedef struct packed {
        logic tdo;
        logic tdo_oe_n;
    } jbs_neg_st_t;

    // System clock domain state
    typedef struct packed {
        logic [NUM_PINS-1:0] latch_out;
        logic [NUM_PINS-1:0] latch_ctl;
        logic tog_seen;
        logic [NUM_PINS-1:0] pad_out;
        logic [NUM_PINS-1:0] pad_oe_n;
    } jbs_sys_st_t;

    jbs_tck_st_t t_reg; // Test clock state
    jbs_tck_st_t t_next; // Its next value
    jbs_neg_st_t n_reg; // Falling-edge state
    jbs_neg_st_t n_next; // Its next value
    jbs_sys_st_t s_reg; // System state
    jbs_sys_st_t s_next; // Its next value
    jbs_instr_t instr; // Decoded current instruction
    jbs_instr_t instr_new; // Decoded instruction being loaded
    logic [XW-1:0] x_tck; // Values crossing into test clock
    logic [2:0] x_sys; // Flags crossing into system clock
    logic [NUM_PINS-1:0] pad_sys; // Pad levels in system domain
    logic serial_bit; // Bit offered to tdo

    // ==========================================================
    // Instruction decode
    // ==========================================================
    function automatic jbs_instr_t decode(input logic [`JBS_IR_W-1:0] ir);
        case (ir[`JBS_OPC_MSB:`JBS_OPC_LSB])
            `JBS_OP_BYPASS: decode = JBS_I_BYPASS;
            `JBS_OP_SAMPLE: decode = JBS_I_SAMPLE;
            `JBS_OP_EXTEST: decode = JBS_I_EXTEST;
            `JBS_OP_IDCODE: decode = JBS_I_IDCODE;
            `JBS_OP_CLAMP: decode = JBS_I_CLAMP;
            `JBS_OP_HIGHZ: decode = JBS_I_HIGHZ;
            default: decode = JBS_I_BYPASS;
        endcase
    endfunction

    assign instr = decode(t_reg.ir);
    assign instr_new = decode(t_reg.ir_sh);

    // ==========================================================
    // Crossings
    // ==========================================================
    // Standby, pad levels and core outputs into the test clock
    jbs_sync #(.W(XW)) u_sync_tck (
        .clk(tck),
        .rst_n(trst_n),
        .d({standby, pad_in, core_out, core_oe_n}),
        .q(x_tck)
    );

    // Mode flags and update toggle into the system clock
    jbs_sync #(.W(3)) u_sync_sys (
        .clk(sys_clk),
        .rst_n(arst_n),
        .d({t_reg.drive, t_reg.highz, t_reg.upd_tog}),
        .q(x_sys)
    );

    // Pad levels into the system clock for the core
    jbs_sync #(.W(NUM_PINS)) u_sync_pad (
        .clk(sys_clk),
        .rst_n(arst_n),
        .d(pad_in),
        .q(pad_sys)
    );

    // ==========================================================
    // Controller and scan registers, rising test clock
    // ==========================================================
    always_comb begin
        t_next = t_reg;
        // State walk on tms
        case (t_reg.tap)
            JBS_TLR: t_next.tap = tms ? JBS_TLR : JBS_RTI;
            JBS_RTI: t_next.tap = tms ? JBS_SEL_DR : JBS_RTI;
            JBS_SEL_DR: t_next.tap = tms ? JBS_SEL_IR : JBS_CAP_DR;
            JBS_CAP_DR: t_next.tap = tms ? JBS_EX1_DR : JBS_SH_DR;
            JBS_SH_DR: t_next.tap = tms ? JBS_EX1_DR : JBS_SH_DR;
            JBS_EX1_DR: t_next.tap = tms ? JBS_UPD_DR : JBS_PAU_DR;
            JBS_PAU_DR: t_next.tap = tms ? JBS_EX2_DR : JBS_PAU_DR;
            JBS_EX2_DR: t_next.tap = tms ? JBS_UPD_DR : JBS_SH_DR;
            JBS_UPD_DR: t_next.tap = tms ? JBS_SEL_DR : JBS_RTI;
            JBS_SEL_IR: t_next.tap = tms ? JBS_TLR : JBS_CAP_IR;
            JBS_CAP_IR: t_next.tap = tms ? JBS_EX1_IR : JBS_SH_IR;
            JBS_SH_IR: t_next.tap = tms ? JBS_EX1_IR : JBS_SH_IR;
            JBS_EX1_IR: t_next.tap = tms ? JBS_UPD_IR : JBS_PAU_IR;
            JBS_PAU_IR: t_next.tap = tms ? JBS_EX2_IR : JBS_PAU_IR;
            JBS_EX2_IR: t_next.tap = tms ? JBS_UPD_IR : JBS_SH_IR;
            JBS_UPD_IR: t_next.tap = tms ? JBS_SEL_DR : JBS_RTI;
            default: t_next.tap = JBS_TLR;
        endcase
        // Per-state actions
        case (t_reg.tap)
            JBS_TLR: begin
                // Test-logic-reset restores the identification instruction
                t_next.ir = `JBS_IR_RESET;
                t_next.drive = 1'b0;
                t_next.highz = 1'b0;
            end
            JBS_CAP_IR: begin
                t_next.ir_sh = `JBS_IR_CAPTURE;
            end
            JBS_SH_IR: begin
                // Sixteen-bit instruction shift, lsb first
                t_next.ir_sh = {tdi, t_reg.ir_sh[`JBS_IR_W-1:1]};
            end
            JBS_UPD_IR: begin
                // New instruction takes effect only when loaded, and never in standby
                if (!x_tck[XW-1]) begin
                    t_next.ir = t_reg.ir_sh;
                    t_next.drive = (instr_new == JBS_I_EXTEST) || (instr_new == JBS_I_CLAMP);
                    t_next.highz = (instr_new == JBS_I_HIGHZ);
                end
            end
            JBS_CAP_DR: begin
                t_next.byp = 1'b0;
                t_next.id_sh = IDCODE_VAL;
                // Snapshot of pads, core outputs and enables; pins are untouched
                if ((instr == JBS_I_SAMPLE) || (instr == JBS_I_EXTEST)) begin
                    t_next.bsr = x_tck[XW-2:0];
                end
            end
            JBS_SH_DR: begin
                // Data path chosen by the current instruction
                case (instr)
                    JBS_I_SAMPLE, JBS_I_EXTEST: begin
                        // Next pass shifts in while the last results shift out
                        t_next.bsr = {tdi, t_reg.bsr[BSR_LEN-1:1]};
                    end
                    JBS_I_IDCODE: begin
                        t_next.id_sh = {tdi, t_reg.id_sh[`JBS_ID_W-1:1]};
                    end
                    default: begin
                        t_next.byp = tdi;
                    end
                endcase
            end
            JBS_UPD_DR: begin
                // Preload or new test pattern; captured values reach pins only here
                if ((instr == JBS_I_SAMPLE) || (instr == JBS_I_EXTEST)) begin
                    t_next.upd_out = t_reg.bsr[NUM_PINS +: NUM_PINS];
                    t_next.upd_ctl = t_reg.bsr[0 +: NUM_PINS];
                    t_next.upd_tog = ~t_reg.upd_tog;
                end
            end
            default: begin
                // Idle, select, exit and pause states hold everything
            end
        endcase
    end

    // Rising test clock register, test reset enters the identification instruction
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            t_reg <= '0;
            t_reg.tap <= JBS_TLR;
            t_reg.ir <= `JBS_IR_RESET;
        end else begin
            t_reg <= t_next;
        end
    end

    // ==========================================================
    // Serial output, falling test clock
    // ==========================================================
    always_comb begin
        if (t_reg.tap == JBS_SH_IR) begin
            serial_bit = t_reg.ir_sh[0];
        end else begin
            case (instr)
                JBS_I_SAMPLE, JBS_I_EXTEST: serial_bit = t_reg.bsr[0];
                JBS_I_IDCODE: serial_bit = t_reg.id_sh[0];
                default: serial_bit = t_reg.byp;
            endcase
        end
    end

    // Drive only in the two shift states
    always_comb begin
        n_next = n_reg;
        n_next.tdo_oe_n = !((t_reg.tap == JBS_SH_IR) || (t_reg.tap == JBS_SH_DR));
        n_next.tdo = n_next.tdo_oe_n ? 1'b0 : serial_bit;
    end

    // Output register on the falling edge
    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            n_reg <= '0;
            n_reg.tdo_oe_n <= 1'b1;
        end else begin
            n_reg <= n_next;
        end
    end

    // ==========================================================
    // Pin control, system clock
    // ==========================================================
    always_comb begin
        s_next = s_reg;
        // Latch copy taken once per update toggle; source is quiet by then
        s_next.tog_seen = x_sys[0];
        if (x_sys[0] != s_reg.tog_seen) begin
            s_next.latch_out = t_reg.upd_out;
            s_next.latch_ctl = t_reg.upd_ctl;
        end
        if (x_sys[1]) begin
            // All pads released
            s_next.pad_out = '0;
            s_next.pad_oe_n = '1;
        end else if (x_sys[2]) begin
            // Pads follow the parallel output latch
            s_next.pad_out = s_reg.latch_out;
            s_next.pad_oe_n = s_reg.latch_ctl;
        end else begin
            // Normal operation unaffected by sample or bypass
            s_next.pad_out = core_out;
            s_next.pad_oe_n = core_oe_n;
        end
    end

    // System register, pads released during reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
            s_reg.pad_oe_n <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tdo = n_reg.tdo;
    assign tdo_oe_n = n_reg.tdo_oe_n;
    assign pad_out = s_reg.pad_out;
    assign pad_oe_n = s_reg.pad_oe_n;
    assign core_in = pad_sys;

endmodule // jbs_tap

// [inc/jbs_defs.svh]
`ifndef JBS_DEFS_SVH
`define JBS_DEFS_SVH

// ==========================================================
// Instruction register layout
// ==========================================================
`define JBS_IR_W 16
`define JBS_OPC_MSB 15
`define JBS_OPC_LSB 12
`define JBS_IR_CAPTURE 16'h0001
`define JBS_IR_RESET 16'h5000

// ==========================================================
// Opcodes held in the upper nibble
// ==========================================================
`define JBS_OP_EXTEST 4'h0
`define JBS_OP_SAMPLE 4'h4
`define JBS_OP_IDCODE 4'h5
`define JBS_OP_CLAMP 4'h6
`define JBS_OP_HIGHZ 4'h7
`define JBS_OP_BYPASS 4'hf

// ==========================================================
// Identification and chain sizes
// ==========================================================
`define JBS_ID_W 32
// Arbitrary identification value, bit 0 set as the standard requires
`define JBS_IDCODE_VAL 32'h0000_0001
`define JBS_NUM_PINS 111

`endif

// [inc/jbs_pkg.sv]
// ==========================================================
// Types shared by the boundary-scan block
// ==========================================================
package jbs_pkg;

    // Test port controller states, Gray coded along the usual walk
    typedef enum logic [3:0] {
        JBS_TLR = 4'h0,
        JBS_RTI = 4'h1,
        JBS_SEL_DR = 4'h3,
        JBS_CAP_DR = 4'h2,
        JBS_SH_DR = 4'h6,
        JBS_EX1_DR = 4'h7,
        JBS_PAU_DR = 4'h5,
        JBS_EX2_DR = 4'h4,
        JBS_UPD_DR = 4'hc,
        JBS_SEL_IR = 4'hd,
        JBS_CAP_IR = 4'hf,
        JBS_SH_IR = 4'he,
        JBS_EX1_IR = 4'ha,
        JBS_PAU_IR = 4'hb,
        JBS_EX2_IR = 4'h9,
        JBS_UPD_IR = 4'h8
    } jbs_tap_t;

    // Decoded instruction
    typedef enum logic [2:0] {
        JBS_I_BYPASS = 3'h0,
        JBS_I_SAMPLE = 3'h1,
        JBS_I_EXTEST = 3'h2,
        JBS_I_IDCODE = 3'h3,
        JBS_I_CLAMP = 3'h4,
        JBS_I_HIGHZ = 3'h5
    } jbs_instr_t;

endpackage

// [core/jbs_sync.sv]
`timescale 1ns/1ps
// ==========================================================
// Two-stage level synchroniser
// ==========================================================
module jbs_sync
    import jbs_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk, // Destination clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [W-1:0] d, // Level from the other domain
    output logic [W-1:0] q // Synchronised level
);

    // Both stages; the first is read only by the second
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } jbs_sync_st_t;

    jbs_sync_st_t st_reg; // Registered state
    jbs_sync_st_t st_next; // Next state

    // Shift the level through two stages
    always_comb begin
        st_next = st_reg;
        st_next.meta = d;
        st_next.stable = st_reg.meta;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.stable;

endmodule // jbs_sync

// [tb/jbs_tap_properties.sv]
`timescale 1ns/1ps
// ==========================================================
// Port checker for the boundary-scan block
// ==========================================================
module jbs_tap_properties
    import jbs_pkg::*;
#(
    parameter int NUM_PINS = 111 // Scanned pins
) (
    input wire logic sys_clk, // System clock
    input wire logic arst_n, // System reset, active low
    input wire logic tck, // Test clock
    input wire logic trst_n, // Test reset, active low
    input wire logic tms, // Mode select
    input wire logic tdi, // Data in
    input wire logic tdo, // Data out
    input wire logic tdo_oe_n, // Data out enable, active low
    input wire logic standby, // Standby level
    input wire logic [NUM_PINS-1:0] pad_in, // Pad levels
    input wire logic [NUM_PINS-1:0] pad_out, // Pad drive values
    input wire logic [NUM_PINS-1:0] pad_oe_n, // Pad enables, active low
    input wire logic [NUM_PINS-1:0] core_out, // Core outputs
    input wire logic [NUM_PINS-1:0] core_oe_n, // Core enables, active low
    input wire logic [NUM_PINS-1:0] core_in // Pads seen by the core
);
    logic tdo_rise_reg; // Data out as seen at the last rising edge
    logic [1:0] up_reg; // System cycles since reset, saturating
    // Remember data out at each rising edge
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo_rise_reg <= 1'b0;
        end else begin
            tdo_rise_reg <= tdo;
        end
    end
    // Count settle cycles after system reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            up_reg <= 2'h0;
        end else if (up_reg != 2'h3) begin
            up_reg <= up_reg + 2'h1;
        end
    end
    // Five ones on mode select reach the reset state
    sequence s_reset_walk;
        tms [*5];
    endsequence
    // Data out enable just fell
    sequence s_enter_shift;
        tdo_oe_n ##1 !tdo_oe_n;
    endsequence
    AST_TDO_IDLE: assert property (@(posedge tck) disable iff (!trst_n) tdo_oe_n |-> !tdo)
        else $error("data out not low while released");
    AST_TDO_FALL: assert property (@(negedge tck) disable iff (!trst_n) tdo == tdo_rise_reg)
        else $error("data out moved during high phase");
    AST_TRST_QUIET: assert property (@(posedge tck) disable iff (!trst_n) $rose(trst_n) |-> tdo_oe_n [*4])
        else $error("data out enabled too soon after reset");
    AST_TLR: assert property (@(posedge tck) disable iff (!trst_n) s_reset_walk |=> tdo_oe_n [*2])
        else $error("data out enabled after reset walk");
    AST_SH_EXIT: assert property (@(posedge tck) disable iff (!trst_n) (!tdo_oe_n && tms) |=> tdo_oe_n)
        else $error("data out still enabled after shift exit");
    AST_SH_HOLD: assert property (@(posedge tck) disable iff (!trst_n) (!tdo_oe_n && !tms) |=> !tdo_oe_n)
        else $error("data out released inside shift");
    AST_SH_ENTRY: assert property (@(posedge tck) disable iff (!trst_n) s_enter_shift |-> !$past(tms))
        else $error("shift entered with mode select high");
    AST_CORE_IN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (up_reg == 2'h3) |-> core_in == $past(pad_in, 2))
        else $error("core input does not follow pads");
endmodule // jbs_tap_properties

bind jbs_tap jbs_tap_properties #(.NUM_PINS(NUM_PINS)) u_props (.sys_clk(sys_clk), .arst_n(arst_n),
    .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .standby(standby),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .core_out(core_out), .core_oe_n(core_oe_n),
    .core_in(core_in));

// [tb/jbs_tester.sv]
`timescale 1ns/1ps
// ==========================================================
// External test controller model
// ==========================================================
module jbs_tester (
    output logic tck, // Test clock, high while idle
    output logic trst_n, // Test reset, active low
    output logic tms, // Mode select
    output logic tdi, // Data in
    input wire logic tdo, // Data out from the device
    input wire logic tdo_oe_n // Data out enable, active low
);
    logic [332:0] last_out; // Bits returned by the last scan
    event scan_done; // Raised when a scan ends
    // Idle levels; clock rests high so standby keeps the state
    initial begin
        tck = 1'b1;
        trst_n = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One period: fall, read data out, rise
    task automatic step(input logic m, input logic d, output logic o);
        #1 tms = m;
        tdi = d;
        #6.5 tck = 1'b0;
        // A released line reads as the inverse of tdo, which the device holds low, so as one
        #7 o = tdo_oe_n ? ~tdo : tdo;
        #0.5 tck = 1'b1;
    endtask
    // Period outside shift; data in toggles as a released line
    task automatic walk(input logic m);
        logic o;
        step(m, ~tdi, o);
    endtask
    // Asynchronous reset, then to idle
    task automatic reset_tap();
        #1 trst_n = 1'b0;
        #20 trst_n = 1'b1;
        walk(1'b0);
    endtask
    // Reset through five ones, then to idle
    task automatic tlr();
        repeat (5) walk(1'b1);
        walk(1'b0);
    endtask
    // Scan n bits through instruction or data path from idle
    task automatic scan(input logic ir, input int n, input logic [332:0] din);
        logic o;
        logic [332:0] got;
        got = '0;
        walk(1'b1);
        if (ir) begin
            walk(1'b1);
        end
        walk(1'b0);
        walk(1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            got[i] = o;
        end
        walk(1'b1);
        walk(1'b0);
        // Result handed over whole, so the next scan cannot clear it before the watcher reads it
        last_out = got;
        -> scan_done;
    endtask
endmodule // jbs_tester

// [tb/test_jbs_tap.sv]
`timescale 1ns/1ps
`include "jbs_defs.svh"
// ==========================================================
// Self-checking bench for the boundary-scan block
// ==========================================================
module test_jbs_tap;
    import jbs_pkg::*;
    localparam int P = `JBS_NUM_PINS; // Pins, three cells each
    typedef struct {logic [332:0] v; int n;} jbs_exp_t;
    logic sys_clk, arst_n, tck, trst_n, tms, tdi, tdo, tdo_oe_n, standby;
    logic [P-1:0] pad_in, pad_out, pad_oe_n, core_out, core_oe_n, core_in;
    int errors = 0, checks = 0, cyc = 0;
    logic [31:0] seed = 32'h0000_001f; // Random state
    logic [332:0] v, pre, cap; // Scratch and chain patterns
    jbs_exp_t exp_q[$]; // Expected scan results

    jbs_tap #(.NUM_PINS(P)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .tck(tck), .trst_n(trst_n),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .standby(standby), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .core_out(core_out), .core_oe_n(core_oe_n), .core_in(core_in));
    jbs_tester u_tst (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

    // System clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Random chain-wide vector
    function automatic logic [332:0] rvec();
        logic [332:0] r;
        for (int i = 0; i < 11; i++) begin
            r = {r[300:0], rnd()};
        end
        return r;
    endfunction
    // Compare for scan results
    task automatic chk_scan(input string name, input logic [332:0] e, input logic [332:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    // Compare for pad drive values and enables
    task automatic chk_pad(input string name, input logic [P-1:0] eo, input logic [P-1:0] ee);
        checks++;
        if ({pad_out, pad_oe_n} !== {eo, ee}) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, {eo, ee}, {pad_out, pad_oe_n});
        end
    endtask
    // Wait n system cycles, then step just past the edge
    task automatic sys_wait(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    // Note the expected result, then scan
    task automatic expect_scan(input logic ir, input int n, input logic [332:0] din, input logic [332:0] e);
        exp_q.push_back('{e, n});
        u_tst.scan(ir, n, din);
    endtask
    // Load an opcode; the capture value comes back out
    task automatic load(input logic [3:0] op);
        expect_scan(1'b1, 16, {op, 12'h000}, 333'h1);
    endtask
    // Eight bits through the one-bit path, which captures zero
    task automatic bypass_scan();
        v = rvec();
        expect_scan(1'b0, 8, v, {v[6:0], 1'b0});
    endtask
    // New random pins
    task automatic new_pins();
        v = rvec();
        pad_in = v[P-1:0];
        core_out = v[2*P-1:P];
        core_oe_n = v[3*P-1:2*P];
    endtask
    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Output watcher: oldest note against each finished scan
    initial begin
        jbs_exp_t ex;
        forever begin
            @(u_tst.scan_done);
            ex = exp_q.pop_front();
            chk_scan("scan", ex.v, u_tst.last_out);
        end
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 4000) begin
            errors++;
            end_sim();
        end
    end
    // Main sequence
    initial begin
        arst_n = 1'b0;
        standby = 1'b0;
        pad_in = '0;
        core_out = '0;
        core_oe_n = '1;
        sys_wait(4);
        arst_n = 1'b1;
        u_tst.reset_tap();
        new_pins();
        sys_wait(4);
        chk_pad("normal pads", core_out, core_oe_n);
        chk_scan("core_in", pad_in, core_in);
        expect_scan(1'b0, 32, '0, `JBS_IDCODE_VAL);
        for (int i = 0; i < 2; i++) begin
            load(i ? 4'h3 : 4'hf);
            bypass_scan();
            chk_pad("bypass pads", core_out, core_oe_n);
        end
        load(4'h4);
        new_pins();
        sys_wait(6);
        pre = rvec();
        expect_scan(1'b0, 333, pre, {pad_in, core_out, core_oe_n});
        chk_pad("sample pads", core_out, core_oe_n);
        sys_wait(6);
        load(4'h0);
        sys_wait(6);
        chk_pad("preload", pre[2*P-1:P], pre[P-1:0]);
        new_pins();
        sys_wait(6);
        cap = rvec();
        expect_scan(1'b0, 333, cap, {pad_in, core_out, core_oe_n});
        sys_wait(6);
        chk_pad("extest pass", cap[2*P-1:P], cap[P-1:0]);
        expect_scan(1'b0, 333, pre, {pad_in, core_out, core_oe_n});
        sys_wait(6);
        chk_pad("next pass", pre[2*P-1:P], pre[P-1:0]);
        load(4'h6);
        sys_wait(6);
        chk_pad("clamp", pre[2*P-1:P], pre[P-1:0]);
        bypass_scan();
        load(4'h7);
        sys_wait(6);
        chk_pad("highz", '0, '1);
        bypass_scan();
        chk_pad("highz held", '0, '1);
        load(4'hf);
        sys_wait(6);
        chk_pad("released", core_out, core_oe_n);
        standby = 1'b1;
        sys_wait(2);
        load(4'h5);
        sys_wait(2);
        standby = 1'b0;
        sys_wait(2);
        bypass_scan();
        u_tst.tlr();
        expect_scan(1'b0, 32, '0, `JBS_IDCODE_VAL);
        load(4'hf);
        u_tst.reset_tap();
        expect_scan(1'b0, 32, '0, `JBS_IDCODE_VAL);
        sys_wait(2);
        end_sim();
    end
endmodule // test_jbs_tap
